// ==== design/aud_top.sv ====
// Chosen here: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
module aud_top (
  input wire logic sys_clk, // core clock
  input wire logic sys_rst, // async reset, active high
  input wire logic [40:0] slotIn, // instruction slot from issue
  input wire logic slotValid, // slot is valid this cycle
  input wire logic qpTrue, // value of the qualifying predicate
  output logic decValid, // registered result valid
  output aud_pkg::aud_op_t decOp, // decoded operation
  output logic decClaim, // slot belongs to this unit
  output logic decFault, // illegal-operation fault
  output logic decNop, // executes as no-operation
  output logic decCmpImm, // compare with immediate
  output logic [2:0] decCmpKind, // compare type and relation bits
  output logic [1:0] decCmpRel, // compare opcode low bits
  output logic [1:0] decSimdSize, // multimedia size bits
  output logic [3:0] decX4, // secondary extension
  output logic [1:0] decX2b, // tertiary extension or count
  output logic [6:0] decSrc3, // source register 3
  output logic [6:0] decSrc2, // source register 2
  output logic [6:0] decDst, // destination register
  output logic [5:0] decQp, // qualifying predicate index
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready // read data ready
);
  typedef struct packed {
    logic swSel;
    logic [40:0] swSlot;
    logic swPred;
    logic [31:0] faultCnt;
    logic resValid;
    aud_pkg::aud_dec_t res;
    logic awHeld;
    logic [7:0] awAddr;
    logic wHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } aud_top_state_t;

  aud_top_state_t st;
  aud_top_state_t next_st;
  logic [40:0] selSlot;
  logic selQp;
  logic selValid;
  logic [31:0] slotLoWord;

  aud_dec_if dec ();

  aud_decoder_core u_core (
    .bus (dec)
  );

  // software mode lets a driver probe encodings without the pipeline
  assign selSlot = st.swSel ? st.swSlot : slotIn;
  assign selQp = st.swSel ? st.swPred : qpTrue;
  assign selValid = st.swSel | slotValid;
  assign dec.slot = selSlot;
  assign dec.qpVal = selQp;
  assign slotLoWord = st.swSlot[31:0];

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    next_st = st;
    next_st.resValid = selValid;
    next_st.res = dec.res;
    // write channel: address and data taken in either order
    if (s_axi_awvalid && st.awready)
    begin
      next_st.awHeld = 1'b1;
      next_st.awAddr = s_axi_awaddr;
      next_st.awready = 1'b0;
    end
    if (s_axi_wvalid && st.wready)
    begin
      next_st.wHeld = 1'b1;
      next_st.wData = s_axi_wdata;
      next_st.wStrb = s_axi_wstrb;
      next_st.wready = 1'b0;
    end
    if (st.awHeld && st.wHeld && !st.bvalid)
    begin
      next_st.awHeld = 1'b0;
      next_st.wHeld = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = aud_pkg::RESP_OKAY;
      case (st.awAddr)
        aud_pkg::OFS_CTRL: if (st.wStrb[0]) next_st.swSel = st.wData[0];
        aud_pkg::OFS_SLOT_LO: next_st.swSlot[31:0] = aud_pkg::apply_strb(slotLoWord, st.wData, st.wStrb);
        aud_pkg::OFS_SLOT_HI:
        begin
          if (st.wStrb[0]) next_st.swSlot[39:32] = st.wData[7:0];
          if (st.wStrb[1]) next_st.swSlot[40] = st.wData[8];
        end
        aud_pkg::OFS_PRED: if (st.wStrb[0]) next_st.swPred = st.wData[0];
        aud_pkg::OFS_FAULT_CNT: next_st.faultCnt = aud_pkg::FAULT_CNT_RST;
        aud_pkg::OFS_RESULT, aud_pkg::OFS_FIELDS: next_st.bresp = aud_pkg::RESP_OKAY;
        default: next_st.bresp = aud_pkg::RESP_SLVERR;
      endcase
    end
    // a fault in the clearing cycle still counts
    if (selValid && dec.res.fault)
      next_st.faultCnt = next_st.faultCnt + 32'h0000_0001;
    if (st.bvalid && s_axi_bready)
    begin
      next_st.bvalid = 1'b0;
      next_st.awready = 1'b1;
      next_st.wready = 1'b1;
    end
    if (s_axi_arvalid && st.arready)
    begin
      next_st.arready = 1'b0;
      next_st.rvalid = 1'b1;
      next_st.rresp = aud_pkg::RESP_OKAY;
      case (s_axi_araddr)
        aud_pkg::OFS_CTRL: next_st.rdata = {31'h0000_0000, st.swSel};
        aud_pkg::OFS_SLOT_LO: next_st.rdata = st.swSlot[31:0];
        aud_pkg::OFS_SLOT_HI: next_st.rdata = {23'h00_0000, st.swSlot[40:32]};
        aud_pkg::OFS_PRED: next_st.rdata = {31'h0000_0000, st.swPred};
        aud_pkg::OFS_RESULT: next_st.rdata = {9'h000, st.res.x2b, st.res.x4, st.res.simdSize, st.res.cmpRel,
          st.res.cmpKind, st.res.cmpImm, st.res.op, st.resValid, st.res.nop, st.res.fault, st.res.claim};
        aud_pkg::OFS_FIELDS: next_st.rdata = {5'h00, st.res.src3, st.res.src2, st.res.dst, st.res.qp};
        aud_pkg::OFS_FAULT_CNT: next_st.rdata = st.faultCnt;
        default:
        begin
          next_st.rdata = 32'h0000_0000;
          next_st.rresp = aud_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (st.rvalid && s_axi_rready)
    begin
      next_st.rvalid = 1'b0;
      next_st.arready = 1'b1;
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st <= '0;
      st.faultCnt <= aud_pkg::FAULT_CNT_RST;
      st.awready <= 1'b1;
      st.wready <= 1'b1;
      st.arready <= 1'b1;
    end
    else
      st <= next_st;
  end

  assign decValid = st.resValid;
  assign decOp = st.res.op;
  assign decClaim = st.res.claim;
  assign decFault = st.res.fault;
  assign decNop = st.res.nop;
  assign decCmpImm = st.res.cmpImm;
  assign decCmpKind = st.res.cmpKind;
  assign decCmpRel = st.res.cmpRel;
  assign decSimdSize = st.res.simdSize;
  assign decX4 = st.res.x4;
  assign decX2b = st.res.x2b;
  assign decSrc3 = st.res.src3;
  assign decSrc2 = st.res.src2;
  assign decDst = st.res.dst;
  assign decQp = st.res.qp;
  assign s_axi_awready = st.awready;
  assign s_axi_wready = st.wready;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = st.arready;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_foreign;
    @(posedge sys_clk) disable iff (sys_rst)
    (selSlot[40:37] != 4'h8 && (selSlot[40:37] < 4'hc || selSlot[40:37] > 4'he))
      |=> (!decClaim && decOp == aud_pkg::OP_NOP && !decFault);
  endproperty
  a_foreign: assert property (p_foreign) else $error("foreign opcode was claimed");

  property p_imm14;
    @(posedge sys_clk) disable iff (sys_rst)
    (selSlot[40:37] == 4'h8 && selSlot[35] == 1'b1)
      |=> (decOp == ($past(selSlot[34]) ? aud_pkg::OP_PTR32_ADD_IMM14 : aud_pkg::OP_ADDS_IMM14));
  endproperty
  a_imm14: assert property (p_imm14) else $error("immediate-14 add misdecoded");

  property p_logic;
    @(posedge sys_clk) disable iff (sys_rst)
    (selSlot[40:33] == 8'h80 && selSlot[32:29] == 4'h3)
      |=> (decOp == aud_pkg::logic_op($past(selSlot[28:27]), 1'b0) && !decFault && !decNop);
  endproperty
  a_logic: assert property (p_logic) else $error("logical op misdecoded");

  property p_ve_pred;
    @(posedge sys_clk) disable iff (sys_rst)
    (selSlot[40:33] == 8'h81) |=> (decOp == aud_pkg::OP_NOP && (decFault == $past(selQp)) && (decNop != decFault));
  endproperty
  a_ve_pred: assert property (p_ve_pred) else $error("reserved extension bit not honoured");

  property p_simd;
    @(posedge sys_clk) disable iff (sys_rst)
    (selSlot[40:37] == 4'h8 && selSlot[35:34] == 2'h1)
      |=> (decSimdSize == $past({selSlot[36], selSlot[33]}) && decX4 == $past(selSlot[32:29])
           && (decOp == aud_pkg::OP_SIMD_ALU || decOp == aud_pkg::OP_PSHLADD2 || decOp == aud_pkg::OP_PSHRADD2));
  endproperty
  a_simd: assert property (p_simd) else $error("multimedia group misrouted");

  property p_cmp;
    @(posedge sys_clk) disable iff (sys_rst)
    (selSlot[40:37] >= 4'hc && selSlot[40:37] <= 4'he)
      |=> (decClaim && decCmpImm == $past(selSlot[35]) && decCmpKind[1:0] == $past({selSlot[33], selSlot[12]})
           && (decCmpKind[2] == ($past(selSlot[36]) && !decCmpImm)));
  endproperty
  a_cmp: assert property (p_cmp) else $error("compare extension bits misdecoded");

  property p_fields;
    @(posedge sys_clk) disable iff (sys_rst)
    selValid |=> (decValid && decSrc3 == $past(selSlot[26:20]) && decSrc2 == $past(selSlot[19:13])
                  && decDst == $past(selSlot[12:6]) && decQp == $past(selSlot[5:0]));
  endproperty
  a_fields: assert property (p_fields) else $error("register fields not presented");

  property p_ignored;
    @(posedge sys_clk) disable iff (sys_rst)
    (selSlot[40:33] == 8'h80 && selSlot[32:29] >= 4'hc) |=> (decNop && !decFault);
  endproperty
  a_ignored: assert property (p_ignored) else $error("ignored encoding not a no-operation");

  property p_reserved;
    @(posedge sys_clk) disable iff (sys_rst)
    (selValid && selSlot[40:33] == 8'h80 && (selSlot[32:29] == 4'h5 || selSlot[32:29] == 4'h7))
      |=> (decFault && (st.faultCnt == $past(st.faultCnt) + 32'h0000_0001 || st.faultCnt == 32'h0000_0001));
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved encoding did not fault");
endmodule : aud_top

// ==== pkg/aud_pkg.sv ====
package aud_pkg;
  // ----------------------------------------
  // instruction slot layout
  // ----------------------------------------
  localparam int INSN_W = 41;
  localparam int OPC_LSB = 37;
  localparam int OPC_W = 4;
  localparam int X2A_LSB = 34;
  localparam int VE_BIT = 33;
  localparam int X4_LSB = 29;
  localparam int X2B_LSB = 27;
  localparam int SRC3_LSB = 20;
  localparam int SRC2_LSB = 13;
  localparam int DST_LSB = 6;
  localparam int QP_LSB = 0;
  localparam int REG_W = 7;
  localparam int QP_W = 6;
  localparam int TB_BIT = 36;
  localparam int TA_BIT = 33;
  localparam int CREL_BIT = 12;
  localparam int ZA_BIT = 36;
  localparam int ZB_BIT = 33;
  localparam int SLOT_HI_W = INSN_W - 32;

  // ----------------------------------------
  // opcode and extension values
  // ----------------------------------------
  localparam logic [3:0] OPC_ALU = 4'h8;
  localparam logic [3:0] OPC_CMP_FIRST = 4'hc;
  localparam logic [3:0] OPC_CMP_LAST = 4'he;
  localparam logic [1:0] X2A_INT = 2'h0;
  localparam logic [1:0] X2A_SIMD = 2'h1;
  localparam logic [1:0] X2A_ADDS14 = 2'h2;
  localparam logic [3:0] X4_ADD = 4'h0;
  localparam logic [3:0] X4_SUB = 4'h1;
  localparam logic [3:0] X4_PTR = 4'h2;
  localparam logic [3:0] X4_LOGIC = 4'h3;
  localparam logic [3:0] X4_SHLADD = 4'h4;
  localparam logic [3:0] X4_PTR_SHL = 4'h6;
  localparam logic [3:0] X4_SUB_IMM8 = 4'h9;
  localparam logic [3:0] X4_LOGIC_IMM8 = 4'hb;
  localparam logic [3:0] X4_IGNORED_FIRST = 4'hc;
  localparam logic [3:0] SIMD_X4_SHL_ADD = 4'h4;
  localparam logic [3:0] SIMD_X4_SHR_ADD = 4'h6;
  localparam logic [1:0] X2B_0 = 2'h0;
  localparam logic [1:0] X2B_1 = 2'h1;

  // ----------------------------------------
  // register map and bus answers
  // ----------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SLOT_LO = 8'h04;
  localparam logic [7:0] OFS_SLOT_HI = 8'h08;
  localparam logic [7:0] OFS_PRED = 8'h0c;
  localparam logic [7:0] OFS_RESULT = 8'h10;
  localparam logic [7:0] OFS_FIELDS = 8'h14;
  localparam logic [7:0] OFS_FAULT_CNT = 8'h18;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] FAULT_CNT_RST = 32'h0000_0000;

  typedef enum logic [4:0] {
    OP_NOP, OP_ADD, OP_ADD1, OP_SUB, OP_SUB1, OP_PTR32_ADD, OP_AND, OP_ANDCM, OP_OR, OP_XOR,
    OP_SHLADD, OP_PTR32_SHLADD, OP_SUB_IMM8, OP_AND_IMM8, OP_ANDCM_IMM8, OP_OR_IMM8, OP_XOR_IMM8,
    OP_ADDS_IMM14, OP_PTR32_ADD_IMM14, OP_CMP, OP_CMP4, OP_SIMD_ALU, OP_PSHLADD2, OP_PSHRADD2
  } aud_op_t;

  typedef struct packed {
    logic claim;
    logic fault;
    logic nop;
    aud_op_t op;
    logic cmpImm;
    logic [2:0] cmpKind;
    logic [1:0] cmpRel;
    logic [1:0] simdSize;
    logic [3:0] x4;
    logic [1:0] x2b;
    logic [REG_W-1:0] src3;
    logic [REG_W-1:0] src2;
    logic [REG_W-1:0] dst;
    logic [QP_W-1:0] qp;
  } aud_dec_t;

  function automatic aud_op_t logic_op(input logic [1:0] sel, input logic imm);
    case (sel)
      2'h0: logic_op = imm ? OP_AND_IMM8 : OP_AND;
      2'h1: logic_op = imm ? OP_ANDCM_IMM8 : OP_ANDCM;
      2'h2: logic_op = imm ? OP_OR_IMM8 : OP_OR;
      default: logic_op = imm ? OP_XOR_IMM8 : OP_XOR;
    endcase
  endfunction : logic_op

  function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] data,
                                             input logic [3:0] strb);
    apply_strb = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        apply_strb[i*8+:8] = data[i*8+:8];
    end
  endfunction : apply_strb
endpackage : aud_pkg

// ==== pkg/aud_dec_if.sv ====
`timescale 1ns/1ps
interface aud_dec_if;
  logic [aud_pkg::INSN_W-1:0] slot;
  logic qpVal;
  aud_pkg::aud_dec_t res;
  modport core (input slot, input qpVal, output res);
  modport user (output slot, output qpVal, input res);
endinterface : aud_dec_if

// ==== design/aud_decoder_core.sv ====
`timescale 1ns/1ps
module aud_decoder_core (
  aud_dec_if.core bus // slot in, decoded result out
);
  aud_pkg::aud_dec_t r;
  logic [3:0] opc;
  logic [1:0] x2a;
  logic [3:0] x4;
  logic [1:0] x2b;
  logic resv;
  logic resvPr;
  logic ign;

  // ----------------------------------------
  // combinational decode
  // ----------------------------------------
  always_comb
  begin
    r = '0;
    r.op = aud_pkg::OP_NOP;
    resv = 1'b0;
    resvPr = 1'b0;
    ign = 1'b0;
    opc = bus.slot[aud_pkg::OPC_LSB+:aud_pkg::OPC_W];
    x2a = bus.slot[aud_pkg::X2A_LSB+:2];
    x4 = bus.slot[aud_pkg::X4_LSB+:4];
    x2b = bus.slot[aud_pkg::X2B_LSB+:2];
    r.src3 = bus.slot[aud_pkg::SRC3_LSB+:aud_pkg::REG_W];
    r.src2 = bus.slot[aud_pkg::SRC2_LSB+:aud_pkg::REG_W];
    r.dst = bus.slot[aud_pkg::DST_LSB+:aud_pkg::REG_W];
    r.qp = bus.slot[aud_pkg::QP_LSB+:aud_pkg::QP_W];
    r.x4 = x4;
    r.x2b = x2b;
    r.simdSize = {bus.slot[aud_pkg::ZA_BIT], bus.slot[aud_pkg::ZB_BIT]};
    if (opc == aud_pkg::OPC_ALU)
    begin
      r.claim = 1'b1;
      case (x2a)
        aud_pkg::X2A_INT:
        begin
          if (bus.slot[aud_pkg::VE_BIT])
            resvPr = 1'b1;
          else
            case (x4)
              aud_pkg::X4_ADD: if (x2b == aud_pkg::X2B_0) r.op = aud_pkg::OP_ADD;
                else if (x2b == aud_pkg::X2B_1) r.op = aud_pkg::OP_ADD1;
                else resv = 1'b1;
              aud_pkg::X4_SUB: if (x2b == aud_pkg::X2B_0) r.op = aud_pkg::OP_SUB1;
                else if (x2b == aud_pkg::X2B_1) r.op = aud_pkg::OP_SUB;
                else resv = 1'b1;
              aud_pkg::X4_PTR: if (x2b == aud_pkg::X2B_0) r.op = aud_pkg::OP_PTR32_ADD;
                else resv = 1'b1;
              aud_pkg::X4_LOGIC: r.op = aud_pkg::logic_op(x2b, 1'b0);
              // shift count sits in the low extension here
              aud_pkg::X4_SHLADD: r.op = aud_pkg::OP_SHLADD;
              aud_pkg::X4_PTR_SHL: r.op = aud_pkg::OP_PTR32_SHLADD;
              aud_pkg::X4_SUB_IMM8: if (x2b == aud_pkg::X2B_1) r.op = aud_pkg::OP_SUB_IMM8;
                else resv = 1'b1;
              aud_pkg::X4_LOGIC_IMM8: r.op = aud_pkg::logic_op(x2b, 1'b1);
              default: if (x4 >= aud_pkg::X4_IGNORED_FIRST) ign = 1'b1;
                else resv = 1'b1;
            endcase
        end
        aud_pkg::X2A_SIMD:
        begin
          if (!bus.slot[aud_pkg::ZA_BIT] && bus.slot[aud_pkg::ZB_BIT] && x4 == aud_pkg::SIMD_X4_SHL_ADD)
            r.op = aud_pkg::OP_PSHLADD2;
          else if (!bus.slot[aud_pkg::ZA_BIT] && bus.slot[aud_pkg::ZB_BIT] && x4 == aud_pkg::SIMD_X4_SHR_ADD)
            r.op = aud_pkg::OP_PSHRADD2;
          else
            r.op = aud_pkg::OP_SIMD_ALU;
        end
        aud_pkg::X2A_ADDS14: r.op = aud_pkg::OP_ADDS_IMM14;
        default: r.op = aud_pkg::OP_PTR32_ADD_IMM14;
      endcase
    end
    else if (opc >= aud_pkg::OPC_CMP_FIRST && opc <= aud_pkg::OPC_CMP_LAST)
    begin
      r.claim = 1'b1;
      r.cmpImm = x2a[1];
      r.op = x2a[0] ? aud_pkg::OP_CMP4 : aud_pkg::OP_CMP;
      r.cmpRel = opc[1:0];
      if (x2a[1])
        r.cmpKind = {1'b0, bus.slot[aud_pkg::TA_BIT], bus.slot[aud_pkg::CREL_BIT]};
      else
        r.cmpKind = {bus.slot[aud_pkg::TB_BIT], bus.slot[aud_pkg::TA_BIT], bus.slot[aud_pkg::CREL_BIT]};
    end
    r.fault = resv | (resvPr & bus.qpVal);
    r.nop = ign | (resvPr & !bus.qpVal);
    if (r.fault || r.nop)
      r.op = aud_pkg::OP_NOP;
  end

  assign bus.res = r;
endmodule : aud_decoder_core

// ==== test/aud_issue_model.sv ====
`timescale 1ns/1ps
module aud_issue_model (
  input wire logic sys_clk, // core clock
  input wire logic [40:0] reqSlot, // slot to issue
  input wire logic reqValid, // issue this cycle
  input wire logic reqQp, // predicate value of the slot
  output logic [40:0] slotIn, // slot to the decoder
  output logic slotValid, // slot valid
  output logic qpTrue // predicate to the decoder
);
  initial
  begin
    slotIn = '0;
    slotValid = 1'b0;
    qpTrue = 1'b0;
  end
  always_ff @(posedge sys_clk)
  begin
    slotValid <= reqValid;
    qpTrue <= reqQp;
    // idle cycles scramble the slot so stale decode cannot pass as valid
    slotIn <= reqValid ? reqSlot : ~slotIn;
  end
endmodule : aud_issue_model

// ==== test/a_unit_opcode_decoder_tb.sv ====
`timescale 1ns/1ps
module a_unit_opcode_decoder_tb;
  logic sys_clk, sys_rst, reqValid, reqQp, slotValid, qpTrue, decValid, decClaim, decFault, decNop, decCmpImm;
  logic [40:0] reqSlot, slotIn;
  aud_pkg::aud_op_t decOp;
  logic [2:0] decCmpKind;
  logic [1:0] decCmpRel, decSimdSize, decX2b, bresp, rresp, r;
  logic [3:0] decX4, wstrb;
  logic [6:0] decSrc3, decSrc2, decDst;
  logic [5:0] decQp;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rnd, d;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  int n_errors, tests_run, nFault;
  aud_pkg::aud_dec_t expQ[$], e;
  logic vQ[$];
  aud_issue_model issue (.sys_clk(sys_clk), .reqSlot(reqSlot), .reqValid(reqValid), .reqQp(reqQp),
    .slotIn(slotIn), .slotValid(slotValid), .qpTrue(qpTrue));
  aud_top uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .slotIn(slotIn), .slotValid(slotValid), .qpTrue(qpTrue),
    .decValid(decValid), .decOp(decOp), .decClaim(decClaim), .decFault(decFault), .decNop(decNop),
    .decCmpImm(decCmpImm), .decCmpKind(decCmpKind), .decCmpRel(decCmpRel), .decSimdSize(decSimdSize),
    .decX4(decX4), .decX2b(decX2b), .decSrc3(decSrc3), .decSrc2(decSrc2), .decDst(decDst), .decQp(decQp),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));
  // ----------------------------------------
  // reference decode
  // ----------------------------------------
  function automatic aud_pkg::aud_dec_t ref_dec(input logic [40:0] s, input logic q);
    aud_pkg::aud_dec_t t;
    int c;
    t = {s[26:20], s[19:13], s[12:6], s[5:0]};
    t.x4 = s[32:29];
    t.x2b = s[28:27];
    t.simdSize = {s[36], s[33]};
    t.claim = (s[40:37] == 4'h8) || (s[40:37] >= 4'hc && s[40:37] <= 4'he);
    t.cmpImm = s[35];
    t.cmpKind = {s[36] & ~s[35], s[33], s[12]};
    t.cmpRel = 2'(s[40:37] - 4'hc);
    c = 0;
    if (s[40:37] == 4'h8)
    begin
      case (s[35:34])
        2'h0:
        begin
          case (s[32:29])
            4'h0: c = s[28] ? -1 : (s[27] ? 2 : 1);
            4'h1: c = s[28] ? -1 : (s[27] ? 3 : 4);
            4'h2: c = (s[28:27] == 2'h0) ? 5 : -1;
            4'h3: c = 6 + s[28:27];
            4'h4: c = 10;
            4'h6: c = 11;
            4'h9: c = (s[28:27] == 2'h1) ? 12 : -1;
            4'hb: c = 13 + s[28:27];
            4'hc, 4'hd, 4'he, 4'hf: c = -2;
            default: c = -1;
          endcase
          if (s[33])
            c = q ? -1 : -2;
        end
        2'h1: c = ({s[36], s[33]} != 2'b01) ? 21 : (s[32:29] == 4'h4) ? 22 : (s[32:29] == 4'h6) ? 23 : 21;
        2'h2: c = 17;
        default: c = 18;
      endcase
    end
    else if (t.claim)
      c = s[34] ? 20 : 19;
    t.fault = (c == -1);
    t.nop = (c == -2);
    t.op = aud_pkg::aud_op_t'(c < 0 ? 0 : c);
    return t;
  endfunction : ref_dec
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic finish_test();
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test
  // ----------------------------------------
  // register bus master
  // ----------------------------------------
  task automatic axi_write(input logic [7:0] a, input logic [31:0] v, input logic [3:0] st, output logic [1:0] rs);
    int n;
    logic hsA, hsW, hsB;
    n = 0;
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= v;
    wstrb <= st;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      // sample the slave mid-cycle so the handshake edge sees settled values
      @(negedge sys_clk);
      hsA = (awready === 1'b1);
      hsW = (wready === 1'b1);
      hsB = (bvalid === 1'b1);
      rs = bresp;
      @(posedge sys_clk);
      n++;
      if (awvalid && hsA)
        awvalid <= 1'b0;
      if (wvalid && hsW)
        wvalid <= 1'b0;
    end
    while (!hsB && n < 200);
    bready <= 1'b0;
    check("write done", n < 200, 1);
  endtask : axi_write
  task automatic axi_read(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    int n;
    logic hsA, hsR;
    n = 0;
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(negedge sys_clk);
      hsA = (arready === 1'b1);
      hsR = (rvalid === 1'b1);
      v = rdata;
      rs = rresp;
      @(posedge sys_clk);
      n++;
      if (arvalid && hsA)
        arvalid <= 1'b0;
    end
    while (!hsR && n < 200);
    rready <= 1'b0;
    check("read done", n < 200, 1);
  endtask : axi_read
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  initial
  begin
    #(20 * 40000);
    n_errors++;
    finish_test();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    logic [40:0] s;
    logic v;
    sys_rst = 1'b1;
    {reqSlot, reqValid, reqQp, awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {n_errors, tests_run, nFault} = '0;
    rnd = 32'h4a90a8b3;
    repeat (16) @(posedge sys_clk);
    sys_rst <= 1'b0;
    axi_read(aud_pkg::OFS_FAULT_CNT, d, r);
    check("count reset", {r, d}, {aud_pkg::RESP_OKAY, aud_pkg::FAULT_CNT_RST});
    for (int i = 0; i < 700; i++)
    begin
      rnd = rnd[0] ? (rnd >> 1) ^ 32'h80200003 : rnd >> 1;
      s = {rnd[8:0], rnd ^ 32'h5a3c_96e1};
      v = (i < 80) || (rnd[12:11] != 2'h0);
      s[40:37] = (rnd[15:13] < 3'h4) ? 4'h8 : (rnd[15:13] == 3'h7) ? rnd[19:16] : 4'h9 + rnd[15:13];
      if (i < 64)
        s[40:27] = {4'h8, 4'h0, 6'(i)};
      else if (i < 80)
        s[40:29] = {4'h8, 1'b0, 2'(i), i[2], (i[3] ? 4'h6 : 4'h4)};
      @(posedge sys_clk);
      reqSlot <= s;
      reqValid <= v;
      reqQp <= rnd[20];
      expQ.push_back(ref_dec(s, rnd[20]));
      vQ.push_back(v);
      nFault += v && expQ[$].fault;
      @(negedge sys_clk);
      if (expQ.size() > 2)
      begin
        e = expQ.pop_front();
        v = vQ.pop_front();
        check("valid", decValid, v);
        if (v)
        begin
          check("claim", decClaim, e.claim);
          check("fault", decFault, e.fault);
          check("nop", decNop, e.nop);
          check("op", decOp, e.op);
          check("regs", {decSrc3, decSrc2, decDst, decQp}, {e.src3, e.src2, e.dst, e.qp});
          check("ext", {decSimdSize, decX4, decX2b}, {e.simdSize, e.x4, e.x2b});
          if (e.op == aud_pkg::OP_CMP || e.op == aud_pkg::OP_CMP4)
            check("cmp", {decCmpImm, decCmpKind, decCmpRel}, {e.cmpImm, e.cmpKind, e.cmpRel});
        end
      end
    end
    @(posedge sys_clk);
    reqValid <= 1'b0;
    repeat (4) @(posedge sys_clk);
    axi_read(aud_pkg::OFS_FAULT_CNT, d, r);
    check("fault count", d, nFault);
    axi_write(aud_pkg::OFS_FAULT_CNT, 32'h0, 4'hf, r);
    axi_read(aud_pkg::OFS_FAULT_CNT, d, r);
    check("count clear", d, 0);
    axi_read(8'h1c, d, r);
    check("unmapped read", {r, d}, {aud_pkg::RESP_SLVERR, 32'h0});
    axi_write(8'h20, 32'h1, 4'hf, r);
    check("unmapped write", r, aud_pkg::RESP_SLVERR);
    axi_write(aud_pkg::OFS_RESULT, 32'hffffffff, 4'hf, r);
    check("ro write", r, aud_pkg::RESP_OKAY);
    s = {4'h8, 1'b0, 2'h3, 1'b1, 1'b0, rnd[31:0]};
    e = ref_dec(s, 1'b0);
    axi_write(aud_pkg::OFS_SLOT_LO, s[31:0], 4'hf, r);
    axi_write(aud_pkg::OFS_SLOT_HI, {23'h0, s[40:32]}, 4'h3, r);
    axi_write(aud_pkg::OFS_PRED, 32'h0, 4'h1, r);
    axi_write(aud_pkg::OFS_CTRL, 32'h1, 4'h1, r);
    repeat (3) @(posedge sys_clk);
    axi_read(aud_pkg::OFS_RESULT, d, r);
    check("result", d & 32'h7f81ff, {e.x2b, e.x4, e.simdSize, 6'h0, e.op, 1'b1, e.nop, e.fault, e.claim});
    axi_read(aud_pkg::OFS_FIELDS, d, r);
    check("fields", d, {5'h0, e.src3, e.src2, e.dst, e.qp});
    axi_write(aud_pkg::OFS_CTRL, 32'h0, 4'h1, r);
    finish_test();
  end
endmodule : a_unit_opcode_decoder_tb
